// ### logic/pssa_map.vh
`ifndef PSSA_MAP_VH
`define PSSA_MAP_VH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define PSSA_IDX_SLOT_CTL 12'h058
`define PSSA_IDX_SLOT_STS 12'h05a
`define PSSA_IDX_DCAP2 12'h064
`define PSSA_IDX_DCTL2 12'h068
`define PSSA_IDX_DSTS2 12'h06a
`define PSSA_IDX_LCAP2 12'h06c

// ----------------------------------------
// Slot status field positions
// ----------------------------------------
`define PSSA_BIT_ATTN 0
`define PSSA_BIT_PFAULT 1
`define PSSA_BIT_LATCH_CHG 2
`define PSSA_BIT_PRES_CHG 3
`define PSSA_BIT_CMD_DONE 4
`define PSSA_BIT_LATCH_ST 5
`define PSSA_BIT_PRES_ST 6
`define PSSA_BIT_ILOCK 7
`define PSSA_BIT_LINK_CHG 8

// ----------------------------------------
// Capability and control field positions
// ----------------------------------------
`define PSSA_BIT_ARI_SUP 5
`define PSSA_BIT_ARI_EN 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PSSA_RST_ARI_SUP 1'h1
`define PSSA_RST_ARI_EN 1'h0
`define PSSA_RST_PRES_ST 1'h1
`define PSSA_RST_SLOT_CTL 16'h0000

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define PSSA_RESP_OKAY 2'h0
`define PSSA_RESP_SLVERR 2'h2

`endif

// ### logic/pssa_regs.v
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pssa_map.vh"
//
// Contract
// R1: Attention button press sets bit 0; software writes one to clear.
// R2: Power fault sets bit 1; write one clears, write zero no effect.
// R3: Any latch sensor change sets bit 2 until written one.
// R4: Any presence detect change sets bit 3 until written one.
// R5: Finished command sets bit 4; stays set until written one.
// R6: One slot control write is one command; done after all actions finish.
// R7: Bit 5 reads latch sensor: zero closed, one open.
// R8: With slot implemented, bit 6 follows presence detect input.
// R9: Downstream port without slot reads bit 6 as constant one.
// R10: Upstream port reads bit 6 as zero; writes ignored.
// R11: Bit 7 follows interlock status input from expander nine.
// R12: Interlock bit forced zero when pins are GPIO or expander disabled.
// R13: Link active indication change sets bit 8; write one clears.
// R14: ARI forwarding supported bit 5 resets one, writable only when unlocked.
// R15: With support clear, ARI forwarding enable reads zero, read-only.
// R16: Upstream port reads support and enable as zero; writes ignored.
// R17: Enable set stops forcing device number zero in Type1 to Type0.
// R18: ARI forwarding enable resets zero, read-write unless forced zero.
// R19: Reserved fields and whole reserved registers read zero, ignore writes.
// R20: W1C writes of zero ignored; ones clear only written positions.
//
module pssa_regs (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [13:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [13:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Port configuration levels
    input wire port_is_upstream,
    input wire slot_implemented,
    input wire hotplug_on_gpio,
    input wire expander_enabled,
    input wire lock_write_enable,
    // Slot and link signals
    input wire attention_button_pulse,
    input wire power_fault_pulse,
    input wire latch_sensor_open,
    input wire presence_detect,
    input wire interlock_status_input,
    input wire link_layer_active_indication,
    // Hot-plug command handshake
    output reg slot_command_issue,
    output reg [15:0] slot_control_value,
    input wire slot_actions_done,
    // ARI forwarding controls
    output wire ari_forward_enable,
    output wire keep_device_number
);

// ----------------------------------------
// Write channel capture
// ----------------------------------------
reg aw_held;
reg [11:0] aw_index;
reg w_held;
reg [31:0] w_data;
reg [3:0] w_strb;

// Each half is taken once and held until the write fires
assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
assign s_axi_wready = ~w_held & ~s_axi_bvalid;

wire aw_take = s_axi_awvalid & s_axi_awready;
wire w_take = s_axi_wvalid & s_axi_wready;
wire wr_fire = aw_held & w_held & ~s_axi_bvalid;

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held <= 1'b0;
        aw_index <= 12'h000;
        w_held <= 1'b0;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
    end else begin
        if (aw_take) begin
            aw_held <= 1'b1;
            aw_index <= s_axi_awaddr[13:2];
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
        if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end
end

// ----------------------------------------
// Write decode
// ----------------------------------------
wire hit_slot_ctl = (aw_index == `PSSA_IDX_SLOT_CTL);
wire hit_slot_sts = (aw_index == `PSSA_IDX_SLOT_STS);
wire hit_dcap2 = (aw_index == `PSSA_IDX_DCAP2);
wire hit_dctl2 = (aw_index == `PSSA_IDX_DCTL2);
wire hit_dsts2 = (aw_index == `PSSA_IDX_DSTS2);
wire hit_lcap2 = (aw_index == `PSSA_IDX_LCAP2);
wire wr_mapped = hit_slot_ctl | hit_slot_sts | hit_dcap2 | hit_dctl2 | hit_dsts2 | hit_lcap2;

wire [15:0] lane_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
wire [15:0] w_low = w_data[15:0] & lane_mask;
wire sts_wr = wr_fire & hit_slot_sts;
// Only set bits in enabled lanes clear flags
wire [15:0] clr_bits = sts_wr ? w_low : 16'h0000; // R20

// ----------------------------------------
// Write response
// ----------------------------------------
// Response waits for both halves, which may arrive in either order
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `PSSA_RESP_OKAY;
    end else if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `PSSA_RESP_OKAY : `PSSA_RESP_SLVERR;
    end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
    end
end

// ----------------------------------------
// Change detection on slot levels
// ----------------------------------------
// First cycle after reset only primes history, so no spurious flags
reg primed;
wire [2:0] level_now;
wire [2:0] level_chg;

// Pins arrive synchronous, so one history flop per level is enough
assign level_now = {link_layer_active_indication, presence_detect, latch_sensor_open};

always @(posedge aclk) begin
    if (!aresetn) begin
        primed <= 1'b0;
    end else begin
        primed <= 1'b1;
    end
end

genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_level
        reg prev;
        always @(posedge aclk) begin
            if (!aresetn) begin
                prev <= 1'b0;
            end else begin
                prev <= level_now[gi];
            end
        end
        assign level_chg[gi] = primed & (prev != level_now[gi]);
    end
endgenerate

wire latch_chg = level_chg[0]; // R3
wire pres_chg = level_chg[1]; // R4
wire link_chg = level_chg[2]; // R13

// ----------------------------------------
// Slot control and command tracking
// ----------------------------------------
// Any write to slot control enabling at least one low lane, even just one, counts as one command
reg cmd_pending;
wire ctl_wr = wr_fire & hit_slot_ctl & (|w_strb[1:0]);
wire cmd_done = cmd_pending & slot_actions_done;

always @(posedge aclk) begin
    if (!aresetn) begin
        slot_control_value <= `PSSA_RST_SLOT_CTL;
        slot_command_issue <= 1'b0;
        cmd_pending <= 1'b0;
    end else begin
        slot_command_issue <= ctl_wr; // R6
        if (ctl_wr) begin
            // Unwritten lane keeps its old byte
            slot_control_value <= (slot_control_value & ~lane_mask) | w_low;
        end
        // A new command restarts the wait; done only counts once issued
        if (ctl_wr) begin
            cmd_pending <= 1'b1; // R6
        end else if (cmd_done) begin
            cmd_pending <= 1'b0; // R6
        end
    end
end

// ----------------------------------------
// Sticky event flags
// ----------------------------------------
// Set wins over a clear landing in the same cycle
reg attn_flag;
reg pfault_flag;
reg latch_chg_flag;
reg pres_chg_flag;
reg cmd_done_flag;
reg link_chg_flag;

always @(posedge aclk) begin
    if (!aresetn) begin
        attn_flag <= 1'b0;
        pfault_flag <= 1'b0;
        latch_chg_flag <= 1'b0;
        pres_chg_flag <= 1'b0;
        cmd_done_flag <= 1'b0;
        link_chg_flag <= 1'b0;
    end else begin
        attn_flag <= (attn_flag & ~clr_bits[`PSSA_BIT_ATTN])
            | attention_button_pulse; // R1
        pfault_flag <= (pfault_flag & ~clr_bits[`PSSA_BIT_PFAULT])
            | power_fault_pulse; // R2
        latch_chg_flag <= (latch_chg_flag & ~clr_bits[`PSSA_BIT_LATCH_CHG])
            | latch_chg; // R3
        pres_chg_flag <= (pres_chg_flag & ~clr_bits[`PSSA_BIT_PRES_CHG])
            | pres_chg; // R4
        cmd_done_flag <= (cmd_done_flag & ~clr_bits[`PSSA_BIT_CMD_DONE])
            | cmd_done; // R5
        link_chg_flag <= (link_chg_flag & ~clr_bits[`PSSA_BIT_LINK_CHG])
            | link_chg; // R13
    end
end

// ----------------------------------------
// Read-only slot state
// ----------------------------------------
reg pres_state;
always @* begin
    if (port_is_upstream) begin
        pres_state = 1'b0; // R10
    end else if (slot_implemented) begin
        pres_state = presence_detect; // R8
    end else begin
        pres_state = `PSSA_RST_PRES_ST; // R9
    end
end

// Expander is the only source of interlock state
wire ilock_state = interlock_status_input & expander_enabled & ~hotplug_on_gpio; // R11 R12

wire [15:0] slot_sts_word;
assign slot_sts_word[`PSSA_BIT_ATTN] = attn_flag;
assign slot_sts_word[`PSSA_BIT_PFAULT] = pfault_flag;
assign slot_sts_word[`PSSA_BIT_LATCH_CHG] = latch_chg_flag;
assign slot_sts_word[`PSSA_BIT_PRES_CHG] = pres_chg_flag;
assign slot_sts_word[`PSSA_BIT_CMD_DONE] = cmd_done_flag;
assign slot_sts_word[`PSSA_BIT_LATCH_ST] = latch_sensor_open; // R7
assign slot_sts_word[`PSSA_BIT_PRES_ST] = pres_state;
assign slot_sts_word[`PSSA_BIT_ILOCK] = ilock_state;
assign slot_sts_word[`PSSA_BIT_LINK_CHG] = link_chg_flag;
// Reserved upper bits tie low
assign slot_sts_word[15:9] = 7'h00; // R19

// ----------------------------------------
// ARI forwarding
// ----------------------------------------
reg ari_sup_q;
reg ari_en_q;

// Upstream port masks both bits on read and on use
wire ari_sup = ari_sup_q & ~port_is_upstream; // R16
assign ari_forward_enable = ari_en_q & ari_sup; // R15 R16
// Keep is what the config request converter sees
assign keep_device_number = ari_forward_enable & ~port_is_upstream; // R17

// Lock strap gates software writes to the supported bit
wire sup_wr = wr_fire & hit_dcap2 & w_strb[0] & lock_write_enable;
wire en_wr = wr_fire & hit_dctl2 & w_strb[0];

always @(posedge aclk) begin
    if (!aresetn) begin
        ari_sup_q <= `PSSA_RST_ARI_SUP; // R14
        ari_en_q <= `PSSA_RST_ARI_EN; // R18
    end else begin
        if (sup_wr & ~port_is_upstream) begin
            ari_sup_q <= w_data[`PSSA_BIT_ARI_SUP]; // R14
        end
        // Clearing support also drops the stored enable
        // Upstream strap too, so no stale enable reappears after a strap change
        if (~ari_sup) begin
            ari_en_q <= 1'b0; // R15
        end else if (en_wr & ari_sup) begin
            ari_en_q <= w_data[`PSSA_BIT_ARI_EN]; // R18
        end
    end
end

// ----------------------------------------
// Read channel
// ----------------------------------------
// One read in flight; a new address waits until the data drains
assign s_axi_arready = ~s_axi_rvalid;
wire ar_take = s_axi_arvalid & s_axi_arready;
wire [11:0] ar_index = s_axi_araddr[13:2];

// ----------------------------------------
// Read decode
// ----------------------------------------
reg [31:0] rd_word;
reg rd_hit;
always @* begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    case (ar_index)
        `PSSA_IDX_SLOT_CTL: begin
            rd_word = {16'h0000, slot_control_value};
        end
        `PSSA_IDX_SLOT_STS: begin
            rd_word = {16'h0000, slot_sts_word};
        end
        `PSSA_IDX_DCAP2: begin
            rd_word[`PSSA_BIT_ARI_SUP] = ari_sup; // R16
        end
        `PSSA_IDX_DCTL2: begin
            rd_word[`PSSA_BIT_ARI_EN] = ari_forward_enable; // R15
        end
        `PSSA_IDX_DSTS2: begin
            rd_word = 32'h00000000; // R19
        end
        `PSSA_IDX_LCAP2: begin
            rd_word = 32'h00000000; // R19
        end
        default: begin
            rd_hit = 1'b0;
        end
    endcase
end

// ----------------------------------------
// Read response
// ----------------------------------------
// Data is latched at the take, so it stands while rvalid waits
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `PSSA_RESP_OKAY;
    end else if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `PSSA_RESP_OKAY : `PSSA_RESP_SLVERR;
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule

// ### tb/pssa_regs_asserts.sv
`timescale 1ns/1ps
`include "pssa_map.vh"
module pssa_regs_asserts (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Read channel
    input wire [13:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    // Straps and side outputs
    input wire port_is_upstream,
    input wire hotplug_on_gpio,
    input wire expander_enabled,
    input wire slot_command_issue,
    input wire ari_forward_enable,
    input wire keep_device_number
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Read data lands one edge after the take, so |=> looks at it
    wire tk = s_axi_arvalid && s_axi_arready;
    wire [11:0] ix = s_axi_araddr[13:2];
    wire rs = tk && ix == `PSSA_IDX_SLOT_STS;
    wire rc = tk && ix == `PSSA_IDX_DCAP2;
    wire rz = tk && (ix == `PSSA_IDX_DSTS2 || ix == `PSSA_IDX_LCAP2);
    wire re = tk && ix == `PSSA_IDX_DCTL2;
    property p_pres_up;
        rs && port_is_upstream |=> !s_axi_rdata[6];
    endproperty
    a_pres_up: assert property (p_pres_up) else $error("presence bit upstream");
    property p_ilock_off;
        rs && (hotplug_on_gpio || !expander_enabled) |=> !s_axi_rdata[7];
    endproperty
    a_ilock_off: assert property (p_ilock_off) else $error("interlock not forced");
    property p_sts_rsvd;
        rs |=> s_axi_rdata[31:9] == 23'h0;
    endproperty
    a_sts_rsvd: assert property (p_sts_rsvd) else $error("status reserved set");
    property p_cap_rsvd;
        rc |=> s_axi_rdata[31:6] == 26'h0 && s_axi_rdata[4:0] == 5'h0;
    endproperty
    a_cap_rsvd: assert property (p_cap_rsvd) else $error("cap reserved set");
    property p_sup_up;
        rc && port_is_upstream |=> !s_axi_rdata[5];
    endproperty
    a_sup_up: assert property (p_sup_up) else $error("support bit upstream");
    property p_zero_regs;
        rz |=> s_axi_rdata == 32'h0;
    endproperty
    a_zero_regs: assert property (p_zero_regs) else $error("reserved reg nonzero");
    property p_en_up;
        port_is_upstream |=> !ari_forward_enable;
    endproperty
    a_en_up: assert property (p_en_up) else $error("enable upstream");
    property p_keep;
        re |=> s_axi_rdata[5] == $past(keep_device_number);
    endproperty
    a_keep: assert property (p_keep) else $error("keep differs from enable");
    property p_cmd_pulse;
        slot_command_issue |=> !slot_command_issue;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command issue held");
    cover property (rs && port_is_upstream);
    cover property (slot_command_issue);
    cover property (ari_forward_enable);
endmodule
bind pssa_regs pssa_regs_asserts chk_i (.*);

// ### tb/pssa_expander_model.sv
`timescale 1ns/1ps
module pssa_expander_model (
    // Clock
    input wire aclk,
    // Command handshake
    input wire slot_command_issue,
    input wire [2:0] lag,
    output reg slot_actions_done
);
    integer cnt = -1;
    initial slot_actions_done = 1'b0;
    // Expander traffic takes lag plus one cycles before all actions report done
    always @(posedge aclk) begin
        slot_actions_done <= (cnt == 0);
        if (slot_command_issue) begin
            cnt <= lag;
        end else if (cnt >= 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ### tb/pssa_regs_test.sv
`timescale 1ns/1ps
module pssa_regs_test;
    reg aclk = 0;
    reg aresetn = 0;
    reg [13:0] aw = 0, ar = 0;
    reg awv = 0, wv = 0, arv = 0, up = 0, slot = 0, gpio = 0, xen = 0, lock = 0;
    reg attn = 0, pf = 0, latch = 0, pres = 0, il = 0, link = 0;
    reg [31:0] wd = 0, d;
    reg [2:0] lag = 0;
    reg [3:0] ws = 4'hf;
    reg [1:0] r;
    wire awr, wrdy, bv, arr, rv, iss, done, en_o, keep;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    wire [15:0] ctl;
    integer n_fail = 0, n_checks = 0, seed = 32'he7bc7f54, i, v, flags = 0, sup = 1, en = 0;
    always #4 aclk = ~aclk;
    pssa_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .port_is_upstream(up),
        .slot_implemented(slot), .hotplug_on_gpio(gpio), .expander_enabled(xen),
        .lock_write_enable(lock), .attention_button_pulse(attn), .power_fault_pulse(pf),
        .latch_sensor_open(latch), .presence_detect(pres), .interlock_status_input(il),
        .link_layer_active_indication(link), .slot_command_issue(iss),
        .slot_control_value(ctl), .slot_actions_done(done), .ari_forward_enable(en_o),
        .keep_device_number(keep));
    pssa_expander_model peer (.aclk(aclk), .slot_command_issue(iss), .lag(lag),
        .slot_actions_done(done));
    task print_verdict;
        begin
            if (n_fail == 0 && n_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task chk_resp(input [1:0] e, input [1:0] g);
        begin
            chk("bus_resp", {30'h0, e}, {30'h0, g});
        end
    endtask
    // Ready is read before the edge's own updates land
    task wr(input [13:0] a, input [31:0] dv, output [1:0] rs);
        begin
            aw <= a;
            wd <= dv;
            awv <= 1'b1;
            wv <= 1'b1;
            do begin
                @(posedge aclk);
                if (awr) awv <= 1'b0;
                if (wrdy) wv <= 1'b0;
            end while (bv !== 1'b1);
            rs = br;
        end
    endtask
    task rc(input [13:0] a, input [31:0] e, input [1:0] er);
        begin
            ar <= a;
            arv <= 1'b1;
            do @(posedge aclk); while (arr !== 1'b1);
            arv <= 1'b0;
            do @(posedge aclk); while (rv !== 1'b1);
            chk("rdata", e, rdat);
            chk_resp(er, rr);
        end
    endtask
    function [31:0] sts();
        sts = {23'h0, flags[8], il & xen & ~gpio, up ? 1'b0 : slot ? pres : 1'b1, latch,
            flags[4:0]};
    endfunction
    initial begin
        #200000;
        n_fail = n_fail + 1;
        print_verdict;
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        rc(14'h168, sts(), 2'h0);
        rc(14'h190, 32'h20, 2'h0);
        rc(14'h1a0, 32'h0, 2'h0);
        for (i = 0; i < 24; i = i + 1) begin
            v = $random(seed);
            {lock, xen, gpio, slot, up} <= v[4:0];
            {pf, attn} <= v[6:5];
            latch <= v[7];
            pres <= v[8];
            il <= v[9];
            link <= v[10];
            flags = flags | v[6:5] | (v[7] ^ latch) << 2 | (v[8] ^ pres) << 3;
            flags = flags | (v[10] ^ link) << 8;
            if (v[0] || !sup) en = 0;
            @(posedge aclk);
            {pf, attn} <= 2'h0;
            repeat (2) @(posedge aclk);
            rc(14'h168, sts(), 2'h0);
            v = $random(seed);
            ws <= {2'h3, v[17:16]};
            wr(14'h168, v, r);
            ws <= 4'hf;
            chk_resp(2'h0, r);
            flags = flags & ~(v & {{8{v[17]}}, {8{v[16]}}});
            rc(14'h168, sts(), 2'h0);
            v = $random(seed);
            lag <= v[2:0];
            wr(14'h160, v, r);
            repeat (12) @(posedge aclk);
            flags = flags | 16;
            chk("ctl_val", {16'h0, v[15:0]}, {16'h0, ctl});
            rc(14'h168, sts(), 2'h0);
            v = $random(seed);
            wr(14'h190, v, r);
            if (lock && !up) sup = v[5];
            if (!sup) en = 0;
            wr(14'h1a0, v >> 8, r);
            if (sup && !up) en = v[13];
            rc(14'h190, {26'h0, sup[0] & !up, 5'h0}, 2'h0);
            rc(14'h1a0, {26'h0, en[0], 5'h0}, 2'h0);
            chk("ari_en", {31'h0, en[0]}, {31'h0, en_o});
            chk("keep", {31'h0, en[0]}, {31'h0, keep});
            wr(14'h1a8, v, r);
            rc(14'h1a8, 32'h0, 2'h0);
            rc(14'h1b0, 32'h0, 2'h0);
            wr(14'h1f0, v, r);
            chk_resp(2'h2, r);
            rc(14'h1f0, 32'h0, 2'h2);
        end
        print_verdict;
    end
endmodule
